// [hw/mls_pkg.sv]
// constants for the modbus link supervisor: parameter indices, resets,
// legal ranges, encodings and timing counts.
// assumes a 200 MHz mclk and a one-cycle millisecond tick from outside.
package mls_pkg;

    // ----------------------------------------------------------------
    // parameter indices (the number after the group prefix)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_RX_TIMEOUT   = 8'h03; // 0.1 s units
    localparam logic [7:0] IDX_REPLY_DELAY  = 8'h04; // ms
    localparam logic [7:0] IDX_SYNC_ENABLE  = 8'h05;
    localparam logic [7:0] IDX_SYNC_ROLE    = 8'h06;
    localparam logic [7:0] IDX_SYNC_VAR     = 8'h07;
    localparam logic [7:0] IDX_SCALE        = 8'h08; // 0.01 units
    localparam logic [7:0] IDX_SEND_IVL     = 8'h09; // ms
    localparam logic [7:0] IDX_PROTOCOL     = 8'h0A;
    localparam logic [7:0] IDX_DP_ADDR      = 8'h0B;
    localparam logic [7:0] IDX_CAN_ADDR     = 8'h0C;
    localparam logic [7:0] IDX_DNET_ADDR    = 8'h0D;
    localparam logic [7:0] IDX_CARD_DELAY   = 8'h0E; // 0.1 ms units
    localparam logic [7:0] IDX_BIT_RATE     = 8'h0F;
    localparam logic [7:0] IDX_DP_FORMAT    = 8'h10;
    localparam logic [7:0] IDX_STATUS       = 8'h40; // read-only status

    // ----------------------------------------------------------------
    // reset values and legal limits
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_RX_TIMEOUT  = 16'h0000;
    localparam logic [15:0] RST_REPLY_DELAY = 16'h0002;
    localparam logic [15:0] RST_SYNC_VAR    = 16'h0001;
    localparam logic [15:0] RST_SCALE       = 16'h0064; // 1.00
    localparam logic [15:0] RST_SEND_IVL    = 16'h00C8; // 0.200 s
    localparam logic [15:0] RST_CARD_ADDR   = 16'h0001;
    localparam logic [15:0] RST_BIT_RATE    = 16'h0017; // 23
    localparam logic [15:0] MAX_RX_TIMEOUT  = 16'h0258; // 60.0 s
    localparam logic [15:0] MIN_REPLY_DELAY = 16'h0001; // 1 ms
    localparam logic [15:0] MAX_REPLY_DELAY = 16'h0014; // 20 ms
    localparam logic [15:0] MAX_SYNC_ROLE   = 16'h0002;
    localparam logic [15:0] MAX_SYNC_VAR    = 16'h0005;
    localparam logic [15:0] MAX_SCALE       = 16'h03E8; // 10.00
    localparam logic [15:0] MAX_SEND_IVL    = 16'h7530; // 30.000 s
    localparam logic [15:0] MAX_PROTOCOL    = 16'h0003;
    localparam logic [15:0] MAX_DP_ADDR     = 16'h007D; // 125
    localparam logic [15:0] MAX_CAN_ADDR    = 16'h007F; // 127
    localparam logic [15:0] MAX_DNET_ADDR   = 16'h003F; // 63
    localparam logic [15:0] MAX_CARD_DELAY  = 16'h07D0; // 200.0 ms
    localparam logic [15:0] MAX_CAN_RATE    = 16'h0003; // ones digit
    localparam logic [15:0] MAX_DNET_RATE   = 16'h0002; // tens digit
    localparam logic [15:0] MAX_DP_FORMAT   = 16'h0004;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [15:0] ROLE_SLAVE      = 16'h0000;
    localparam logic [15:0] ROLE_VENDOR     = 16'h0002;
    localparam logic [15:0] PROTO_RTU       = 16'h0000;
    localparam logic [15:0] PROTO_DP        = 16'h0001;
    localparam logic [15:0] PROTO_CAN       = 16'h0002;
    localparam logic [7:0]  FAULT_CODE_COMM = 8'h10;
    localparam logic [16:0] MS_PER_TENTH_S  = 17'h00064; // 100
    localparam logic [31:0] SCALE_DIVISOR   = 32'h00000064; // 1.00

    // ----------------------------------------------------------------
    // timing: card delay resolution of 0.1 ms from mclk
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS    = 5000;
    localparam int CARD_TICK_PS     = 100000000; // 0.1 ms
    localparam int CARD_TICK_CYCLES = CARD_TICK_PS / CLK_PERIOD_PS;

endpackage : mls_pkg

// [hw/mls_link_supervisor.sv]
// modbus link supervisor: receive watchdog, reply delay, master-slave
// synchronisation and expansion card settings of a drive.
// assumes frame checks, millisecond tick and storage done come from the
// uart/protocol logic, all synchronous to mclk.
//
// Summary of operation
// - timeout limit 0..60.0 s, zero disables
// - valid frame gap beyond limit is timeout
// - timeout raises communication fault code
// - reply waits 1..20 ms after valid frame
// - storage writes add their time to delay
// - valid needs function, length and crc ok
// - sync feature only when enable equals 1
// - role: slave, modbus master, vendor master
// - master sends variable picked by selector
// - slave scales received value by 0.00..10.00
// - master repeats send every 0..30.000 s
// - slave follows commands from the master
// - protocol selector picks rtu or card
// - per-card node address with own range
// - card reply delay 0..200.0 ms
// - bit rate digits: canopen ones, devicenet tens
// - dp format selects one of five codes
`timescale 1ns/10ps
`default_nettype none

module mls_link_supervisor
#(
    parameter int CARD_TICK_CYCLES = mls_pkg::CARD_TICK_CYCLES
)
(
    input  wire logic        mclk,           // system clock
    input  wire logic        rst_n,          // async reset
    input  wire logic        msTick,         // one-cycle ms pulse
    input  wire logic        frameEnd,       // end of received frame
    input  wire logic        funcCodeOk,     // function code correct
    input  wire logic        lengthOk,       // data length correct
    input  wire logic        crcOk,          // crc correct
    input  wire logic        needsStore,     // request writes nvm
    input  wire logic        storeDone,      // nvm write finished
    input  wire logic        faultClear,     // clears timeout fault
    input  wire logic        paramWrite,     // parameter write strobe
    input  wire logic [7:0]  paramIndex,     // parameter index
    input  wire logic [15:0] paramWdata,     // write value
    input  wire logic [15:0] outFreq,        // sync source 0
    input  wire logic [15:0] setFreq,        // sync source 1
    input  wire logic [15:0] outTorque,      // sync source 2
    input  wire logic [15:0] setTorque,      // sync source 3
    input  wire logic [15:0] pidSetpoint,    // sync source 4
    input  wire logic [15:0] outCurrent,     // sync source 5
    input  wire logic        syncRxValid,    // sync value received
    input  wire logic [15:0] syncRxValue,    // received sync value
    input  wire logic        cardDataIn,     // master sent card data
    output logic      [15:0] paramRdata,     // read value
    output logic             paramError,     // refused write
    output logic             replyStart,     // start the response
    output logic             commTimeoutFault, // sticky timeout
    output logic      [7:0]  faultCode,      // active fault code
    output logic             syncSendPulse,  // master send now
    output logic             syncSendVendor, // send on vendor bus
    output logic      [15:0] syncSendValue,  // value to send
    output logic             syncFollowActive, // slave mode on
    output logic             syncFollowValid,  // scaled value ready
    output logic      [15:0] syncFollowValue,  // scaled value
    output logic      [1:0]  protocolSel,    // active protocol
    output logic      [6:0]  cardAddress,    // address of chosen card
    output logic      [1:0]  canRate,        // canopen rate code
    output logic      [1:0]  dnetRate,       // devicenet rate code
    output logic      [2:0]  dpFormat,       // dp format code
    output logic             cardReplyStart  // card reply now
);
    import mls_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (CARD_TICK_CYCLES < 2 || CARD_TICK_CYCLES > 65535)
    begin : g_bad_tick
        $error("card tick count out of range");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        RS_IDLE  = 3'b001,   // nothing pending
        RS_STORE = 3'b010,   // waiting for nvm write
        RS_DELAY = 3'b100    // counting reply delay
    } mls_reply_t;

    typedef struct packed {
        logic [16:3][15:0] cfg;       // parameter registers
        logic [16:0]       wdogCnt;   // ms since last valid frame
        logic              fault;     // timeout fault
        mls_reply_t        rstate;    // reply sequencer
        logic [4:0]        replyCnt;  // elapsed ms of reply delay
        logic [15:0]       sendCnt;   // ms since last master send
        logic              cardBusy;  // card delay running
        logic [15:0]       preCnt;    // 0.1 ms prescaler
        logic [10:0]       cardCnt;   // elapsed 0.1 ms units
        logic [15:0]       rdata;
        logic              perr;
        logic              reply;
        logic [7:0]        fcode;
        logic              sendPulse;
        logic              sendVendor;
        logic [15:0]       sendValue;
        logic              follow;
        logic              followValid;
        logic [15:0]       followValue;
        logic [1:0]        proto;
        logic [6:0]        addr;
        logic [1:0]        canR;
        logic [1:0]        dnetR;
        logic [2:0]        dpF;
        logic              cardReply;
    } mls_state_t;

    mls_state_t st;       // registered state
    mls_state_t next_st;  // next state

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // legality of a write; refused writes keep the old value
    function automatic logic inRange(input logic [7:0]  idx,
                                     input logic [15:0] v);
        logic ok;
        ok = 1'b0;
        case (idx)
            IDX_RX_TIMEOUT:  ok = (v <= MAX_RX_TIMEOUT);
            IDX_REPLY_DELAY: ok = (v >= MIN_REPLY_DELAY) &&
                                  (v <= MAX_REPLY_DELAY);
            IDX_SYNC_ENABLE: ok = (v <= 16'h0001);
            IDX_SYNC_ROLE:   ok = (v <= MAX_SYNC_ROLE);
            IDX_SYNC_VAR:    ok = (v <= MAX_SYNC_VAR);
            IDX_SCALE:       ok = (v <= MAX_SCALE);
            IDX_SEND_IVL:    ok = (v <= MAX_SEND_IVL);
            IDX_PROTOCOL:    ok = (v <= MAX_PROTOCOL);
            IDX_DP_ADDR:     ok = (v != 16'h0000) && (v <= MAX_DP_ADDR);
            IDX_CAN_ADDR:    ok = (v != 16'h0000) && (v <= MAX_CAN_ADDR);
            IDX_DNET_ADDR:   ok = (v <= MAX_DNET_ADDR);
            IDX_CARD_DELAY:  ok = (v <= MAX_CARD_DELAY);
            IDX_BIT_RATE:    ok = ((v % 16'd10) <= MAX_CAN_RATE) &&
                                  ((v / 16'd10) <= MAX_DNET_RATE);
            IDX_DP_FORMAT:   ok = (v <= MAX_DP_FORMAT);
            default:         ok = 1'b0;
        endcase
        return ok;
    endfunction : inRange

    // received value times factor in hundredths, saturating at 16 bits
    function automatic logic [15:0] scaleValue(input logic [15:0] v,
                                               input logic [15:0] f);
        logic [31:0] q;
        q = (32'(v) * 32'(f)) / SCALE_DIVISOR;
        return (q > 32'h0000FFFF) ? 16'hFFFF : q[15:0];
    endfunction : scaleValue

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    logic        validFrame;   // frame passes every check
    logic [16:0] limitMs;      // watchdog limit in ms
    logic        syncOn;       // master-slave feature enabled
    logic [4:0]  wIdx;         // index into cfg, 0x10 needs five bits

    always_comb
    begin
        validFrame = frameEnd && funcCodeOk && lengthOk && crcOk;
        limitMs    = 17'(st.cfg[3]) * MS_PER_TENTH_S;
        syncOn     = (st.cfg[5] == 16'h0001);
        wIdx       = paramIndex[4:0];
        next_st    = st;
        // pulses last one cycle
        next_st.perr        = 1'b0;
        next_st.reply       = 1'b0;
        next_st.sendPulse   = 1'b0;
        next_st.followValid = 1'b0;
        next_st.cardReply   = 1'b0;

        // parameter writes, range checked
        if (paramWrite)
        begin
            if (inRange(paramIndex, paramWdata))
                next_st.cfg[wIdx] = paramWdata;
            else
                next_st.perr = 1'b1;  // unknown index or bad value
        end

        // read mux, answer one cycle after the index is presented
        if (paramIndex >= IDX_RX_TIMEOUT && paramIndex <= IDX_DP_FORMAT)
            next_st.rdata = st.cfg[wIdx];
        else if (paramIndex == IDX_STATUS)
            next_st.rdata = {12'h000, st.cardBusy, st.rstate != RS_IDLE,
                             st.follow, st.fault};
        else
            next_st.rdata = 16'h0000;

        // receive watchdog
        if (st.cfg[3] == 16'h0000)
            next_st.wdogCnt = 17'h00000;  // disabled, even in sync mode
        else if (validFrame)
            next_st.wdogCnt = 17'h00000;
        else if (msTick && st.wdogCnt <= limitMs)
            next_st.wdogCnt = st.wdogCnt + 17'h00001;
        // set wins over clear so a late timeout is never lost
        if (st.cfg[3] != 16'h0000 && st.wdogCnt > limitMs)
            next_st.fault = 1'b1;
        else if (faultClear)
            next_st.fault = 1'b0;
        next_st.fcode = next_st.fault ? FAULT_CODE_COMM : 8'h00;

        // reply sequencer; a new valid frame restarts it
        case (st.rstate)
            RS_IDLE:
            begin
                // nothing to do until a request arrives
            end
            RS_STORE:
            begin
                if (storeDone)
                    next_st.rstate = RS_DELAY;
            end
            RS_DELAY:
            begin
                if (msTick)
                begin
                    if (st.replyCnt + 5'd1 >= st.cfg[4][4:0])
                    begin
                        next_st.reply  = 1'b1;
                        next_st.rstate = RS_IDLE;
                    end
                    else
                        next_st.replyCnt = st.replyCnt + 5'd1;
                end
            end
            default:
                next_st.rstate = RS_IDLE;
        endcase
        if (validFrame)
        begin
            next_st.replyCnt = 5'd0;
            // storage time is added before the configured delay
            next_st.rstate = needsStore ? RS_STORE : RS_DELAY;
        end

        // master: periodic send of the selected variable
        if (syncOn && st.cfg[6] != ROLE_SLAVE)
        begin
            if (msTick)
            begin
                // interval zero sends on every tick
                if (st.sendCnt + 16'd1 >= st.cfg[9])
                begin
                    next_st.sendCnt   = 16'd0;
                    next_st.sendPulse = 1'b1;
                    next_st.sendVendor = (st.cfg[6] == ROLE_VENDOR);
                    case (st.cfg[7][2:0])
                        3'h0:    next_st.sendValue = outFreq;
                        3'h1:    next_st.sendValue = setFreq;
                        3'h2:    next_st.sendValue = outTorque;
                        3'h3:    next_st.sendValue = setTorque;
                        3'h4:    next_st.sendValue = pidSetpoint;
                        default: next_st.sendValue = outCurrent;
                    endcase
                end
                else
                    next_st.sendCnt = st.sendCnt + 16'd1;
            end
        end
        else
            next_st.sendCnt = 16'd0;

        // slave: scale and pass on what the master sends
        next_st.follow = syncOn && (st.cfg[6] == ROLE_SLAVE);
        if (st.follow && syncRxValid)
        begin
            next_st.followValid = 1'b1;
            next_st.followValue = scaleValue(syncRxValue, st.cfg[8]);
        end

        // expansion card settings
        next_st.proto = st.cfg[10][1:0];
        case (st.cfg[10])
            PROTO_RTU: next_st.addr = 7'h00;
            PROTO_DP:  next_st.addr = st.cfg[11][6:0];
            PROTO_CAN: next_st.addr = st.cfg[12][6:0];
            default:   next_st.addr = st.cfg[13][6:0];
        endcase
        next_st.canR  = 2'((st.cfg[15] % 16'd10));
        next_st.dnetR = 2'((st.cfg[15] / 16'd10));
        // format only meaningful with the dp card
        next_st.dpF = (st.cfg[10] == PROTO_DP) ? st.cfg[16][2:0]
                                               : 3'h0;

        // card process data reply delay in 0.1 ms units
        if (cardDataIn && st.cfg[10] != PROTO_RTU)
        begin
            next_st.cardBusy = 1'b1;
            next_st.preCnt   = 16'd0;
            next_st.cardCnt  = 11'd0;
        end
        else if (st.cardBusy)
        begin
            if (st.cardCnt >= st.cfg[14][10:0])
            begin
                next_st.cardReply = 1'b1;
                next_st.cardBusy  = 1'b0;
            end
            else if (st.preCnt == 16'(CARD_TICK_CYCLES - 1))
            begin
                next_st.preCnt  = 16'd0;
                next_st.cardCnt = st.cardCnt + 11'd1;
            end
            else
                next_st.preCnt = st.preCnt + 16'd1;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st        <= '0;
            st.rstate <= RS_IDLE;
            st.cfg[3]  <= RST_RX_TIMEOUT;
            st.cfg[4]  <= RST_REPLY_DELAY;
            st.cfg[7]  <= RST_SYNC_VAR;
            st.cfg[8]  <= RST_SCALE;
            st.cfg[9]  <= RST_SEND_IVL;
            st.cfg[11] <= RST_CARD_ADDR;
            st.cfg[12] <= RST_CARD_ADDR;
            st.cfg[13] <= RST_CARD_ADDR;
            st.cfg[15] <= RST_BIT_RATE;
            st.canR    <= 2'h3;
            st.dnetR   <= 2'h2;
        end
        else
            st <= next_st;
    end

    // ----------------------------------------------------------------
    // outputs, all straight from the state register
    // ----------------------------------------------------------------
    assign paramRdata       = st.rdata;
    assign paramError       = st.perr;
    assign replyStart       = st.reply;
    assign commTimeoutFault = st.fault;
    assign faultCode        = st.fcode;
    assign syncSendPulse    = st.sendPulse;
    assign syncSendVendor   = st.sendVendor;
    assign syncSendValue    = st.sendValue;
    assign syncFollowActive = st.follow;
    assign syncFollowValid  = st.followValid;
    assign syncFollowValue  = st.followValue;
    assign protocolSel      = st.proto;
    assign cardAddress      = st.addr;
    assign canRate          = st.canR;
    assign dnetRate         = st.dnetR;
    assign dpFormat         = st.dpF;
    assign cardReplyStart   = st.cardReply;

endmodule : mls_link_supervisor

`default_nettype wire

// [test/mls_monitor.sv]
// port checker for mls_link_supervisor, bound to every instance
// assumes one mclk domain and an async active-low rst_n
`timescale 1ns/10ps
`default_nettype none
module mls_monitor
import mls_pkg::*;
(
    input wire logic        mclk, rst_n, paramWrite, faultClear,
    input wire logic        syncRxValid, paramError, replyStart,
    input wire logic        commTimeoutFault, syncFollowActive,
    input wire logic        syncFollowValid,
    input wire logic [7:0]  paramIndex, faultCode,
    input wire logic [15:0] paramWdata,
    input wire logic [1:0]  protocolSel, dnetRate,
    input wire logic [6:0]  cardAddress,
    input wire logic [2:0]  dpFormat
);
    // ----------------------------------------------------------------
    // single domain: clock and reset given once
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_zero_delay: assert property (paramWrite && paramWdata == 16'h0000
        && paramIndex == IDX_REPLY_DELAY |=> paramError) else $error("zero");
    a_addr_range: assert property (paramWrite && paramIndex == IDX_DP_ADDR
        && paramWdata > MAX_DP_ADDR |=> paramError) else $error("addr");
    a_fault_code: assert property (faultCode ==
        (commTimeoutFault ? FAULT_CODE_COMM : 8'h00)) else $error("code");
    a_fault_hold: assert property (commTimeoutFault && !faultClear
        |=> commTimeoutFault) else $error("fault lost");
    a_reply_pulse: assert property (replyStart |=> !replyStart)
        else $error("reply long");
    a_follow_gate: assert property (syncRxValid && !syncFollowActive
        |=> !syncFollowValid) else $error("follow off");
    a_follow_cause: assert property (syncFollowValid
        |-> $past(syncRxValid)) else $error("follow cause");
    // guard on a settled selector, the card outputs change in the same cycle as it
    a_dp_gate: assert property ($stable(protocolSel)
        && protocolSel != 2'h1 |-> dpFormat == 3'h0) else $error("dp");
    a_rtu_addr: assert property ($stable(protocolSel)
        && protocolSel == 2'h0 |-> cardAddress == 7'h00) else $error("rtu");
    a_dnet_rate: assert property (dnetRate != 2'h3)
        else $error("dnet rate");
    c_reply: cover property (replyStart);
    c_fault: cover property ($rose(commTimeoutFault));
    c_follow: cover property (syncFollowValid);
endmodule : mls_monitor
bind mls_link_supervisor mls_monitor u_mon (.mclk, .rst_n, .paramWrite,
    .faultClear, .syncRxValid, .paramError, .replyStart, .commTimeoutFault,
    .syncFollowActive, .syncFollowValid, .paramIndex, .faultCode,
    .paramWdata, .protocolSel, .dnetRate, .cardAddress, .dpFormat);
`default_nettype wire

// [test/mls_master_model.sv]
// far-side master: frame end strobe with the three check levels
// assumes the bench asks for a frame through go for one cycle
`timescale 1ns/10ps
`default_nettype none
module mls_master_model
(
    input  wire logic       mclk,
    input  wire logic       go,
    input  wire logic [2:0] okBits,
    output logic            frameEnd,
    output logic [2:0]      chk
);
    initial {frameEnd, chk} = 4'h0;
    // outside a frame the check lines wander, nothing stale to lean on
    always @(negedge mclk)
    begin
        frameEnd <= go;
        chk      <= go ? okBits : ~chk;
    end
endmodule : mls_master_model
`default_nettype wire

// [test/mls_link_supervisor_test.sv]
// bench for mls_link_supervisor: parameter port, frames, ticks, sync
// assumes mls_master_model as frame source and mls_monitor via bind
`timescale 1ns/10ps
`default_nettype none
module mls_link_supervisor_test;
import mls_pkg::*;
logic mclk = 0, rst_n = 0, msTick = 0, go = 0, needsStore = 0, storeDone = 0;
logic faultClear = 0, paramWrite = 0, syncRxValid = 0, cardDataIn = 0;
logic [2:0] okBits = 3'h7, chk;
logic [7:0] paramIndex = 8'h00, faultCode;
logic [15:0] paramWdata = 0, syncRxValue = 0, paramRdata, syncSendValue;
logic [15:0] src [6] = '{default: 16'h0000}, syncFollowValue;
logic [6:0] cardAddress;
logic [2:0] dpFormat;
logic [1:0] protocolSel, canRate, dnetRate;
logic paramError, replyStart, commTimeoutFault, syncSendPulse, h, frameEnd;
logic syncSendVendor, syncFollowActive, syncFollowValid, cardReplyStart;
int failures = 0, total_checks = 0, cyc = 0, n, c, s;
always #2.5 mclk = ~mclk;
mls_master_model PEER (.mclk, .go, .okBits, .frameEnd, .chk);
mls_link_supervisor #(.CARD_TICK_CYCLES(10)) DUT (.mclk, .rst_n, .msTick,
    .frameEnd, .funcCodeOk(chk[2]), .lengthOk(chk[1]), .crcOk(chk[0]),
    .needsStore, .storeDone, .faultClear, .paramWrite, .paramIndex,
    .paramWdata, .outFreq(src[0]), .setFreq(src[1]), .outTorque(src[2]),
    .setTorque(src[3]), .pidSetpoint(src[4]), .outCurrent(src[5]),
    .syncRxValid, .syncRxValue, .cardDataIn, .paramRdata, .paramError,
    .replyStart, .commTimeoutFault, .faultCode, .syncSendPulse,
    .syncSendVendor, .syncSendValue, .syncFollowActive, .syncFollowValid,
    .syncFollowValue, .protocolSel, .cardAddress, .canRate, .dnetRate,
    .dpFormat, .cardReplyStart);
task final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask : final_report
task cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
        failures++;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
endtask : cmp
// one parameter access: refusal seen after one edge, value after two
task acc(input logic w, input logic [7:0] i, input logic [15:0] d,
         input logic e, input logic [15:0] x);
    @(negedge mclk) {paramWrite, paramIndex, paramWdata} <= {w, i, d};
    @(negedge mclk) paramWrite <= 1'b0;
    cmp(paramError, e);
    @(negedge mclk) cmp(paramRdata, x);
endtask : acc
task frame(input logic [2:0] ok, input logic st);
    @(negedge mclk) {go, okBits, needsStore} <= {1'b1, ok, st};
    @(negedge mclk) go <= 1'b0;
    @(negedge mclk) needsStore <= 1'b0;
endtask : frame
// ms ticks every fourth cycle until the watched output shows
task ticks(input int w, input int m);
    h = 1'b0;
    n = 0;
    for (c = 0; c < m * 4 && !h; c++)
    begin
        @(negedge mclk);
        h = ((w == 0) ? replyStart : (w == 1) ? commTimeoutFault
            : (w == 2) ? syncSendPulse : cardReplyStart) === 1'b1;
        msTick <= !h && (c % 4 == 0);
        n += (!h && (c % 4 == 0));
    end
endtask : ticks
task follow(input logic [15:0] f, v, input logic ev, input logic [15:0] e);
    acc(1, IDX_SCALE, f, 0, f);
    @(negedge mclk) {syncRxValid, syncRxValue} <= {1'b1, v};
    @(negedge mclk) syncRxValid <= 1'b0;
    cmp(syncFollowValid, ev);
    if (ev) cmp(syncFollowValue, e);
endtask : follow
always @(negedge mclk) if (++cyc == 40000) begin failures++; final_report(); end
initial
begin
    repeat (10) @(negedge mclk);
    rst_n <= 1'b1;
    acc(0, IDX_SYNC_VAR, 0, 0, RST_SYNC_VAR);
    acc(0, IDX_SEND_IVL, 0, 0, RST_SEND_IVL);
    acc(0, IDX_BIT_RATE, 0, 0, RST_BIT_RATE);
    cmp({canRate, dnetRate}, 4'hE);
    acc(1, IDX_STATUS, 1, 1, 0);
    acc(1, IDX_RX_TIMEOUT, 601, 1, 0);
    acc(1, IDX_REPLY_DELAY, 0, 1, 2);
    acc(1, IDX_REPLY_DELAY, 21, 1, 2);
    acc(1, IDX_DP_ADDR, 126, 1, 1);
    acc(1, IDX_CAN_ADDR, 127, 0, 127);
    acc(1, IDX_DNET_ADDR, 64, 1, 1);
    acc(1, IDX_DNET_ADDR, 0, 0, 0);
    acc(1, IDX_BIT_RATE, 13, 0, 13);
    cmp({canRate, dnetRate}, 4'hD);
    acc(1, IDX_BIT_RATE, 36, 1, 13);
    acc(1, IDX_SYNC_ROLE, 3, 1, 0);
    acc(1, IDX_DP_FORMAT, 5, 1, 0);
    acc(1, IDX_DP_FORMAT, 4, 0, 4);
    for (s = 3; s >= 0; s--)
    begin
        acc(1, IDX_PROTOCOL, s, 0, s);
        cmp({protocolSel, cardAddress}, {s[1:0], s == 2 ? 7'h7F : 7'(s == 1)});
        cmp(dpFormat, s == 1 ? 4 : 0);
    end
    acc(1, IDX_PROTOCOL, 2, 0, 2);
    acc(1, IDX_CARD_DELAY, 3, 0, 3);
    @(negedge mclk) cardDataIn <= 1'b1;
    @(negedge mclk) cardDataIn <= 1'b0;
    ticks(3, 20);
    cmp(c >= 30 && c <= 34, 1);
    acc(1, IDX_PROTOCOL, 0, 0, 0);
    frame(7, 0);
    ticks(0, 10);
    cmp(n, 2);
    foreach (src[j]) acc(1, IDX_REPLY_DELAY, j * 19 % 20 + 1, 0, j * 19 % 20 + 1);
    for (s = 0; s < 3; s++) begin frame(3'h7 ^ (3'h1 << s), 0); ticks(0, 25); cmp(h, 0); end
    frame(7, 1);
    ticks(0, 25);
    cmp(h, 0);
    @(negedge mclk) storeDone <= 1'b1;
    @(negedge mclk) storeDone <= 1'b0;
    ticks(0, 25);
    cmp(n, 16);
    acc(1, IDX_RX_TIMEOUT, 1, 0, 1);
    frame(7, 0);
    ticks(1, 50);
    frame(6, 0);
    ticks(1, 200);
    cmp({n[7:0], faultCode}, {8'd51, FAULT_CODE_COMM});
    frame(7, 0);
    @(negedge mclk) faultClear <= 1'b1;
    @(negedge mclk) faultClear <= 1'b0;
    acc(1, IDX_RX_TIMEOUT, 0, 0, 0);
    ticks(1, 120);
    cmp({h, commTimeoutFault}, 0);
    acc(1, IDX_SYNC_ENABLE, 1, 0, 1);
    acc(1, IDX_SYNC_ROLE, 1, 0, 1);
    acc(1, IDX_SEND_IVL, 1, 0, 1);
    for (s = 0; s < 6; s++)
    begin
        foreach (src[j]) src[j] <= 16'(j * 256 + s);
        acc(1, IDX_SYNC_VAR, s, 0, s);
        ticks(2, 3);
        ticks(2, 3);
        cmp({syncSendVendor, syncSendValue}, 17'(s * 257));
    end
    acc(1, IDX_SYNC_ROLE, 2, 0, 2);
    acc(1, IDX_SEND_IVL, 3, 0, 3);
    ticks(2, 10);
    ticks(2, 10);
    cmp({syncSendVendor, n[7:0]}, {1'b1, 8'd3});
    acc(1, IDX_SYNC_ROLE, 0, 0, 0);
    cmp(syncFollowActive, 1);
    follow(50, 16'h0100, 1, 16'h0080);
    follow(1000, 16'h2000, 1, 16'hFFFF);
    acc(1, IDX_SYNC_ENABLE, 0, 0, 0);
    follow(100, 16'h0300, 0, 16'h0000);
    final_report();
end
endmodule : mls_link_supervisor_test
`default_nettype wire
